/* gpio_port_bank.sv */
// General-purpose port bank: latches, direction, pull-ups, analog sharing
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module gpio_port_bank (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [gpio_bank_pkg::ADDR_W-1:0] addr_i,
    input wire logic [gpio_bank_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [gpio_bank_pkg::DATA_W-1:0] rdata_o,
    // Group zero
    input wire logic [gpio_bank_pkg::W0-1:0] pin0_i,
    output logic [gpio_bank_pkg::W0-1:0] pin0_o,
    output logic [gpio_bank_pkg::W0-1:0] pin0_oe_n_o,
    output logic [gpio_bank_pkg::W0-1:0] pullup0_o,
    // Group one
    input wire logic [gpio_bank_pkg::W1-1:0] pin1_i,
    output logic [gpio_bank_pkg::W1-1:0] pin1_o,
    output logic [gpio_bank_pkg::W1-1:0] pin1_oe_n_o,
    output logic [gpio_bank_pkg::W1-1:0] pullup1_o,
    // Group three
    input wire logic [gpio_bank_pkg::W3-1:0] pin3_i,
    output logic [gpio_bank_pkg::W3-1:0] pin3_o,
    output logic [gpio_bank_pkg::W3-1:0] pin3_oe_n_o,
    output logic [gpio_bank_pkg::W3-1:0] pullup3_o,
    // Group four
    input wire logic [gpio_bank_pkg::W4-1:0] pin4_i,
    output logic [gpio_bank_pkg::W4-1:0] pin4_o,
    output logic [gpio_bank_pkg::W4-1:0] pin4_oe_n_o,
    output logic [gpio_bank_pkg::W4-1:0] pullup4_o,
    // Group six, open drain
    input wire logic [gpio_bank_pkg::W6-1:0] pin6_i,
    output logic [gpio_bank_pkg::W6-1:0] pin6_o,
    output logic [gpio_bank_pkg::W6-1:0] pin6_oe_n_o,
    // Group seven
    input wire logic [gpio_bank_pkg::W7-1:0] pin7_i,
    output logic [gpio_bank_pkg::W7-1:0] pin7_o,
    output logic [gpio_bank_pkg::W7-1:0] pin7_oe_n_o,
    output logic [gpio_bank_pkg::W7-1:0] pullup7_o,
    // Group eight, shared with converter
    input wire logic [gpio_bank_pkg::W8-1:0] pin8_i,
    output logic [gpio_bank_pkg::W8-1:0] pin8_o,
    output logic [gpio_bank_pkg::W8-1:0] pin8_oe_n_o,
    output logic [gpio_bank_pkg::W8-1:0] analog_sel_o,
    output logic [gpio_bank_pkg::W8-1:0] converter_ch_o
);
    localparam int DW = gpio_bank_pkg::DATA_W;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [DW-1:0] latch_reg [gpio_bank_pkg::NGRP];
    logic [DW-1:0] dir_reg [gpio_bank_pkg::NGRP];
    logic [DW-1:0] pu_reg [gpio_bank_pkg::NGRP];
    logic [3:0] analog_digital_pin_config;
    logic [2:0] converter_channel_select;
    logic [DW-1:0] rdata_next;
    logic [DW-1:0] pins_raw [gpio_bank_pkg::NGRP];
    logic [DW-1:0] pins_sync [gpio_bank_pkg::NGRP];
    logic [DW-1:0] width_mask [gpio_bank_pkg::NGRP];
    logic [DW-1:0] pu_mask [gpio_bank_pkg::NGRP];

    localparam int W8M = gpio_bank_pkg::W8;
    logic [W8M-1:0] digital8;

    // Digital-pin mask from the count of digital pins, lowest first
    function automatic logic [W8M-1:0] digital_mask(input logic [3:0] cfg);
        logic [W8M-1:0] m;
        m = '0;
        for (int i = 0; i < W8M; i++) begin
            if (i < int'(cfg)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : digital_mask

    // One-hot channel select
    function automatic logic [W8M-1:0] channel_onehot(input logic [2:0] ch);
        logic [W8M-1:0] m;
        m = '0;
        m[ch] = 1'b1;
        return m;
    endfunction : channel_onehot

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Group index from the low address bits
    wire [3:0] idx = addr_i[3:0];
    wire idx_ok = idx < 4'(gpio_bank_pkg::NGRP);
    wire sel_data = (addr_i[5:4] == gpio_bank_pkg::DATA_BASE[5:4]) && idx_ok;
    wire sel_dir = (addr_i[5:4] == gpio_bank_pkg::DIR_BASE[5:4]) && idx_ok;
    wire sel_pu = (addr_i[5:4] == gpio_bank_pkg::PU_BASE[5:4]) && idx_ok;
    wire sel_cfg = addr_i == gpio_bank_pkg::PINCFG_ADDR;
    wire sel_chan = addr_i == gpio_bank_pkg::CHAN_ADDR;
    wire [2:0] gi = idx[2:0];

    // Digital pin count clamped to the group width
    wire [3:0] cfg_clamped = (wdata_i[3:0] > 4'(W8M)) ? 4'(W8M) : wdata_i[3:0]; // [RL16]

    // Implemented bits per group; group 0..6 = ports 0,1,3,4,6,7,8
    assign width_mask[0] = 8'h07; // [RL1]
    assign width_mask[1] = 8'hff; // [RL3]
    assign width_mask[2] = 8'h0f; // [RL6]
    assign width_mask[3] = 8'h03; // [RL7]
    assign width_mask[4] = 8'h0f; // [RL8]
    assign width_mask[5] = 8'h0f; // [RL9]
    assign width_mask[6] = 8'hff; // [RL10]

    // Groups with pull-up option; six and eight have none
    assign pu_mask[0] = width_mask[0];
    assign pu_mask[1] = width_mask[1];
    assign pu_mask[2] = width_mask[2];
    assign pu_mask[3] = width_mask[3];
    assign pu_mask[4] = 8'h00; // [RL8]
    assign pu_mask[5] = width_mask[5];
    assign pu_mask[6] = 8'h00; // [RL10]

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pins_raw[0] = {5'h0_0, pin0_i};
    assign pins_raw[1] = pin1_i;
    assign pins_raw[2] = {4'h0, pin3_i};
    assign pins_raw[3] = {6'h0_0, pin4_i};
    assign pins_raw[4] = {4'h0, pin6_i};
    assign pins_raw[5] = {4'h0, pin7_i};
    assign pins_raw[6] = pin8_i;

    for (genvar g = 0; g < gpio_bank_pkg::NGRP; g++) begin : g_sync
        pin_sync #(.WIDTH(DW)) u_sync (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .async_i(pins_raw[g]),
            .sync_o(pins_sync[g])
        );
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int g = 0; g < gpio_bank_pkg::NGRP; g++) begin
                latch_reg[g] <= gpio_bank_pkg::LATCH_RESET;
                dir_reg[g] <= gpio_bank_pkg::DIR_RESET; // [RL11]
                pu_reg[g] <= gpio_bank_pkg::PU_RESET;
            end
            analog_digital_pin_config <= gpio_bank_pkg::PINCFG_RESET; // [RL15]
            converter_channel_select <= gpio_bank_pkg::CHAN_RESET;
        end else if (wr_i) begin
            if (sel_data) latch_reg[gi] <= wdata_i & width_mask[gi]; // [RL17]
            if (sel_dir) dir_reg[gi] <= wdata_i | ~width_mask[gi];
            if (sel_pu) pu_reg[gi] <= wdata_i & pu_mask[gi]; // [RL2] [RL4]
            if (sel_cfg) analog_digital_pin_config <= cfg_clamped; // [RL16]
            if (sel_chan) converter_channel_select <= wdata_i[2:0];
        end
    end

    // ------------------------------------------------------------
    // Read path: input bits show pins, output bits the latch
    // ------------------------------------------------------------
    wire [DW-1:0] data_view = ((pins_sync[gi] & dir_reg[gi]) | (latch_reg[gi] & ~dir_reg[gi])) & width_mask[gi]; // [RL17]
    wire [DW-1:0] data8_view = data_view & ((gi == 3'd6) ? digital8 : 8'hff); // [RL12]

    // Register read select, zero when idle
    always_comb begin
        rdata_next = gpio_bank_pkg::UNMAPPED_READ;
        if (rd_i) begin
            if (sel_data) rdata_next = data8_view;
            else if (sel_dir) rdata_next = dir_reg[gi];
            else if (sel_pu) rdata_next = pu_reg[gi];
            else if (sel_cfg) rdata_next = {4'h0, analog_digital_pin_config};
            else if (sel_chan) rdata_next = {5'h0_0, converter_channel_select};
        end
    end

    // Digital pins of group eight, lowest first
    assign digital8 = digital_mask(analog_digital_pin_config);

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    // Read data stands one cycle, zero otherwise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rdata_next; // [RL17]
        end
    end

    // ------------------------------------------------------------
    // Group zero drive: output enable low while driving
    // ------------------------------------------------------------
    // Pull-up only for an input pin
    wire [gpio_bank_pkg::W0-1:0] pin0_next = latch_reg[0][2:0];
    wire [gpio_bank_pkg::W0-1:0] oe0_n_next = dir_reg[0][2:0]; // [RL1]
    wire [gpio_bank_pkg::W0-1:0] pullup0_next = pu_reg[0][2:0] & dir_reg[0][2:0]; // [RL2] [RL18]

    // Group zero output flops, input mode at reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin0_o <= '0;
            pin0_oe_n_o <= '1; // [RL11]
            pullup0_o <= '0;
        end else begin
            pin0_o <= pin0_next;
            pin0_oe_n_o <= oe0_n_next;
            pullup0_o <= pullup0_next;
        end
    end

    // ------------------------------------------------------------
    // Group one drive
    // ------------------------------------------------------------
    // Pull-up only for an input pin
    wire [gpio_bank_pkg::W1-1:0] pin1_next = latch_reg[1];
    wire [gpio_bank_pkg::W1-1:0] oe1_n_next = dir_reg[1]; // [RL3]
    wire [gpio_bank_pkg::W1-1:0] pullup1_next = pu_reg[1] & dir_reg[1]; // [RL4] [RL18]

    // Group one output flops, input mode at reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin1_o <= '0;
            pin1_oe_n_o <= '1; // [RL11]
            pullup1_o <= '0;
        end else begin
            pin1_o <= pin1_next;
            pin1_oe_n_o <= oe1_n_next;
            pullup1_o <= pullup1_next;
        end
    end

    // ------------------------------------------------------------
    // Group three drive
    // ------------------------------------------------------------
    // Pull-up only for an input pin
    wire [gpio_bank_pkg::W3-1:0] pin3_next = latch_reg[2][3:0];
    wire [gpio_bank_pkg::W3-1:0] oe3_n_next = dir_reg[2][3:0]; // [RL6]
    wire [gpio_bank_pkg::W3-1:0] pullup3_next = pu_reg[2][3:0] & dir_reg[2][3:0]; // [RL6] [RL18]

    // Group three output flops, input mode at reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin3_o <= '0;
            pin3_oe_n_o <= '1; // [RL11]
            pullup3_o <= '0;
        end else begin
            pin3_o <= pin3_next;
            pin3_oe_n_o <= oe3_n_next;
            pullup3_o <= pullup3_next;
        end
    end

    // ------------------------------------------------------------
    // Group four drive
    // ------------------------------------------------------------
    // Pull-up only for an input pin
    wire [gpio_bank_pkg::W4-1:0] pin4_next = latch_reg[3][1:0];
    wire [gpio_bank_pkg::W4-1:0] oe4_n_next = dir_reg[3][1:0]; // [RL7]
    wire [gpio_bank_pkg::W4-1:0] pullup4_next = pu_reg[3][1:0] & dir_reg[3][1:0]; // [RL7] [RL18]

    // Group four output flops, input mode at reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin4_o <= '0;
            pin4_oe_n_o <= '1; // [RL11]
            pullup4_o <= '0;
        end else begin
            pin4_o <= pin4_next;
            pin4_oe_n_o <= oe4_n_next;
            pullup4_o <= pullup4_next;
        end
    end

    // ------------------------------------------------------------
    // Group six drive: open drain, pulls low only
    // ------------------------------------------------------------
    // Enable only for an output bit whose latch is low
    wire [gpio_bank_pkg::W6-1:0] oe6_n_next = dir_reg[4][3:0] | latch_reg[4][3:0]; // [RL8]

    // Group six output flops; the data line never goes high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin6_o <= '0;
            pin6_oe_n_o <= '1; // [RL11]
        end else begin
            pin6_o <= '0; // [RL8]
            pin6_oe_n_o <= oe6_n_next;
        end
    end

    // ------------------------------------------------------------
    // Group seven drive
    // ------------------------------------------------------------
    // Pull-up only for an input pin
    wire [gpio_bank_pkg::W7-1:0] pin7_next = latch_reg[5][3:0];
    wire [gpio_bank_pkg::W7-1:0] oe7_n_next = dir_reg[5][3:0]; // [RL9]
    wire [gpio_bank_pkg::W7-1:0] pullup7_next = pu_reg[5][3:0] & dir_reg[5][3:0]; // [RL9] [RL18]

    // Group seven output flops, input mode at reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin7_o <= '0;
            pin7_oe_n_o <= '1; // [RL11]
            pullup7_o <= '0;
        end else begin
            pin7_o <= pin7_next;
            pin7_oe_n_o <= oe7_n_next;
            pullup7_o <= pullup7_next;
        end
    end

    // ------------------------------------------------------------
    // Group eight drive: digital output pins only
    // ------------------------------------------------------------
    // Analog pins never drive, whatever the direction bit
    wire [W8M-1:0] pin8_next = latch_reg[6];
    wire [W8M-1:0] oe8_n_next = ~(digital8 & ~dir_reg[6]); // [RL13] [RL14]

    // Group eight output flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin8_o <= '0;
            pin8_oe_n_o <= '1;
        end else begin
            pin8_o <= pin8_next;
            pin8_oe_n_o <= oe8_n_next;
        end
    end

    // ------------------------------------------------------------
    // Converter routing
    // ------------------------------------------------------------
    // Channel routed only for an analog input pin
    wire [W8M-1:0] analog_next = ~digital8;
    wire [W8M-1:0] analog_in8 = analog_next & dir_reg[6];
    wire [W8M-1:0] converter_next = channel_onehot(converter_channel_select) & analog_in8; // [RL14]

    // Converter flops; all pins analog at reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            analog_sel_o <= '1; // [RL15]
            converter_ch_o <= '0;
        end else begin
            analog_sel_o <= analog_next; // [RL12]
            converter_ch_o <= converter_next;
        end
    end
endmodule : gpio_port_bank

/* gpio_bank_pkg.sv */
// Constants and register map for the general-purpose port bank
//
// Summary of operation
// RL1: Group zero: three pins, latch and direction each
// RL2: Group zero input pull-up when enable bit set
// RL3: Group one: eight latched pins, per-bit direction
// RL4: Group one input pull-up per enable bit
// RL5: Software keeps serial registers at default for ports
// RL6: Group three: four pins, direction, input pull-ups
// RL7: Group four: two pins, direction, pull-up enable
// RL8: Group six: four open-drain pins, no pull-up
// RL9: Group seven: four pins, direction, input pull-ups
// RL10: Group eight: eight pins, no pull-up, analog shared
// RL11: Reset puts groups 0-7 pins in input
// RL12: Group eight digital input needs digital and input
// RL13: Group eight drives only when digital and output
// RL14: Analog with output prohibited; analog input via channel
// RL15: Reset makes all group eight pins analog
// RL16: Software assigns digital pins from lowest upward
// RL17: Data read gives pin in input, latch otherwise
// RL18: Pull-up off whenever pin is output
package gpio_bank_pkg;

    // ------------------------------------------------------------
    // Register bus layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Group widths
    // ------------------------------------------------------------
    localparam int W0 = 3;
    localparam int W1 = 8;
    localparam int W3 = 4;
    localparam int W4 = 2;
    localparam int W6 = 4;
    localparam int W7 = 4;
    localparam int W8 = 8;
    localparam int NGRP = 7;

    // ------------------------------------------------------------
    // Register offsets: data, direction, pull-up, per group index
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] DATA_BASE = 6'h00;
    localparam logic [ADDR_W-1:0] DIR_BASE = 6'h10;
    localparam logic [ADDR_W-1:0] PU_BASE = 6'h20;
    localparam logic [ADDR_W-1:0] PINCFG_ADDR = 6'h30;
    localparam logic [ADDR_W-1:0] CHAN_ADDR = 6'h31;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;
    localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
    localparam logic [DATA_W-1:0] PU_RESET = 8'h00;
    localparam logic [3:0] PINCFG_RESET = 4'h0;
    localparam logic [2:0] CHAN_RESET = 3'h0;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

endpackage : gpio_bank_pkg

/* pin_sync.sv */
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            sync_o <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule : pin_sync

/* pin_world.sv */
// Behavioural model of the circuits hanging on one group of port pins
`timescale 1ns/1ps
module pin_world #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic [W-1:0] oe_n_i,
    input wire logic [W-1:0] out_i,
    input wire logic [W-1:0] pu_i,
    input wire logic [W-1:0] drv_i,
    input wire logic [W-1:0] ext_i,
    output logic [W-1:0] lvl_o
);
    logic [W-1:0] last_reg = '0;
    // Port drive wins, then the outside driver, then pull-up; a floating line wanders
    assign lvl_o = (~oe_n_i & out_i) | (oe_n_i & ((drv_i & ext_i) | (~drv_i & (pu_i | ~last_reg))));
    // Keep last level so a floating line never repeats it
    always_ff @(posedge clk_i) begin
        last_reg <= lvl_o;
    end
endmodule : pin_world

/* gpio_port_bank_sva.sv */
// Port-level assertions for the general-purpose port bank
`timescale 1ns/1ps
module gpio_port_bank_sva (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [5:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [2:0] pin0_oe_n_o,
    input wire logic [2:0] pullup0_o,
    input wire logic [3:0] pin6_o,
    input wire logic [3:0] pin7_oe_n_o,
    input wire logic [7:0] pin8_oe_n_o,
    input wire logic [7:0] analog_sel_o,
    input wire logic [7:0] converter_ch_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_wr(logic [5:0] a);
        wr_i && addr_i == a;
    endsequence
    sequence s_rd(logic [5:0] a);
        rd_i && addr_i == a;
    endsequence
    property p_rd_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    property p_rst_dir;
        !$past(rst_n_i) |-> (&pin0_oe_n_o) && (&pin7_oe_n_o);
    endproperty
    a_rst_dir: assert property (p_rst_dir)
        else $error("pin driven after reset");
    property p_rst_ana;
        !$past(rst_n_i) |-> analog_sel_o == 8'hff;
    endproperty
    a_rst_ana: assert property (p_rst_ana)
        else $error("group eight not analog after reset");
    property p_od_low;
        pin6_o == 4'h0;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open drain pin driven high");
    property p_pu_off;
        (pullup0_o & ~pin0_oe_n_o) == 3'h0;
    endproperty
    a_pu_off: assert property (p_pu_off)
        else $error("pull-up on driven pin");
    property p_g8_drv;
        (analog_sel_o & ~pin8_oe_n_o) == 8'h00;
    endproperty
    a_g8_drv: assert property (p_g8_drv)
        else $error("analog pin driven");
    property p_conv;
        $onehot0(converter_ch_o) && (converter_ch_o & ~analog_sel_o) == 8'h00;
    endproperty
    a_conv: assert property (p_conv)
        else $error("converter channel on digital pin");
    property p_dir0;
        s_wr(gpio_bank_pkg::DIR_BASE) |-> ##2 pin0_oe_n_o == $past(wdata_i[2:0], 2);
    endproperty
    a_dir0: assert property (p_dir0)
        else $error("direction write not applied");
    property p_pu0;
        s_wr(gpio_bank_pkg::PU_BASE) |-> ##2 pullup0_o == ($past(wdata_i[2:0], 2) & pin0_oe_n_o);
    endproperty
    a_pu0: assert property (p_pu0)
        else $error("pull-up write not applied");
    property p_dir_rd;
        s_rd(gpio_bank_pkg::DIR_BASE) |=> rdata_o == {5'h1f, pin0_oe_n_o};
    endproperty
    a_dir_rd: assert property (p_dir_rd)
        else $error("direction read wrong");
endmodule : gpio_port_bank_sva

bind gpio_port_bank gpio_port_bank_sva gpio_port_bank_sva_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin0_oe_n_o(pin0_oe_n_o),
    .pullup0_o(pullup0_o), .pin6_o(pin6_o), .pin7_oe_n_o(pin7_oe_n_o), .pin8_oe_n_o(pin8_oe_n_o),
    .analog_sel_o(analog_sel_o), .converter_ch_o(converter_ch_o));

/* gpio_port_bank_tb.sv */
// Self-checking bench for the general-purpose port bank
`timescale 1ns/1ps
module gpio_port_bank_tb;
    localparam int WD [7] = '{3, 8, 4, 2, 4, 4, 8};
    localparam logic [5:0] DAT = gpio_bank_pkg::DATA_BASE;
    localparam logic [5:0] DIR = gpio_bank_pkg::DIR_BASE;
    localparam logic [5:0] PUB = gpio_bank_pkg::PU_BASE;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] addr_i = 6'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] ext_v = 8'hc6;
    logic [7:0] drv_v = 8'hff;
    logic [7:0] m, e;
    wire [7:0] rdata_o, analog_sel_o, converter_ch_o;
    wire [7:0] pi_a [7], po_a [7], oe_a [7], pu_a [7];
    int err_count = 0;
    int checked = 0;
    int cyc = 0;

    gpio_port_bank gpio_port_bank_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .analog_sel_o(analog_sel_o), .converter_ch_o(converter_ch_o),
        .pin0_i(pi_a[0][2:0]), .pin0_o(po_a[0][2:0]), .pin0_oe_n_o(oe_a[0][2:0]), .pullup0_o(pu_a[0][2:0]),
        .pin1_i(pi_a[1]), .pin1_o(po_a[1]), .pin1_oe_n_o(oe_a[1]), .pullup1_o(pu_a[1]),
        .pin3_i(pi_a[2][3:0]), .pin3_o(po_a[2][3:0]), .pin3_oe_n_o(oe_a[2][3:0]), .pullup3_o(pu_a[2][3:0]),
        .pin4_i(pi_a[3][1:0]), .pin4_o(po_a[3][1:0]), .pin4_oe_n_o(oe_a[3][1:0]), .pullup4_o(pu_a[3][1:0]),
        .pin6_i(pi_a[4][3:0]), .pin6_o(po_a[4][3:0]), .pin6_oe_n_o(oe_a[4][3:0]),
        .pin7_i(pi_a[5][3:0]), .pin7_o(po_a[5][3:0]), .pin7_oe_n_o(oe_a[5][3:0]), .pullup7_o(pu_a[5][3:0]),
        .pin8_i(pi_a[6]), .pin8_o(po_a[6]), .pin8_oe_n_o(oe_a[6]));

    // Outside world per group; group six has a board pull-up, group eight none
    for (genvar g = 0; g < 7; g++) begin : g_pins
        pin_world #(.W(WD[g])) pin_world_i (.clk_i(clk_i), .oe_n_i(oe_a[g][WD[g]-1:0]), .out_i(po_a[g][WD[g]-1:0]),
            .pu_i(g == 4 ? {WD[g]{1'b1}} : g == 6 ? {WD[g]{1'b0}} : pu_a[g][WD[g]-1:0]),
            .drv_i(drv_v[WD[g]-1:0]), .ext_i(ext_v[WD[g]-1:0]), .lvl_o(pi_a[g][WD[g]-1:0]));
    end

    // ------------------------------------------------------------
    // Clock, watchdog and bus tasks
    // ------------------------------------------------------------
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count = err_count + 1;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_i);
            wr_i <= 1'b0;
            rd_i <= 1'b0;
        end
    endtask : tick
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
    endtask : wr
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 cmp(rdata_o, exp);
    endtask : rd

    // Main sequence: reset state, per-group traffic, analog sharing
    initial begin
        tick(16);
        rst_n_i <= 1'b1;
        tick(2);
        #1 cmp(analog_sel_o, 8'hff);
        cmp(converter_ch_o, 8'h01);
        for (int g = 0; g < 7; g++) begin
            rd(DIR + 6'(g), 8'hff);
            rd(PUB + 6'(g), 8'h00);
        end
        for (int g = 0; g < 7; g++) begin
            m = 8'((9'h001 << WD[g]) - 9'h001);
            e = (g == 4 ? 8'h7e : g == 6 ? 8'hff : 8'h5a) & m;
            wr(DIR + 6'(g), 8'h5a);
            wr(DAT + 6'(g), 8'h3c);
            wr(PUB + 6'(g), 8'hff);
            tick(5);
            #1 cmp(oe_a[g] & m, e);
            cmp(po_a[g] & ~e & m, 8'h3c & ~e & m);
            if (g != 4 && g != 6) cmp(pu_a[g] & m, 8'h5a & m);
            rd(DAT + 6'(g), g == 6 ? 8'h00 : 8'h66 & m);
            rd(DIR + 6'(g), 8'h5a | ~m);
            rd(PUB + 6'(g), (g == 4 || g == 6) ? 8'h00 : m);
        end
        drv_v <= 8'h00;
        tick(4);
        rd(DAT + 6'h01, 8'h7e);
        drv_v <= 8'hff;
        wr(gpio_bank_pkg::PINCFG_ADDR, 8'h03);
        wr(gpio_bank_pkg::CHAN_ADDR, 8'h06);
        tick(5);
        #1 cmp(analog_sel_o, 8'hf8);
        cmp(oe_a[6], 8'hfa);
        cmp(converter_ch_o, 8'h40);
        rd(DAT + 6'h06, 8'h06);
        wr(gpio_bank_pkg::PINCFG_ADDR, 8'h09);
        rd(6'h3f, 8'h00);
        tick(5);
        #1 cmp(analog_sel_o, 8'h00);
        cmp(converter_ch_o, 8'h00);
        cmp(oe_a[6], 8'h5a);
        cmp(po_a[6], 8'h3c);
        rd(DAT + 6'h06, 8'h66);
        rst_n_i = 1'b0;
        tick(2);
        rst_n_i <= 1'b1;
        tick(2);
        #1 cmp(oe_a[1], 8'hff);
        cmp(analog_sel_o, 8'hff);
        give_verdict();
    end
endmodule : gpio_port_bank_tb
